// [shared/motion_rd_pkg.sv]
// package: command codes, status bit positions, environment bit positions
// assumes: 32-bit register data, 8-bit command codes, 16-bit status words
package motion_rd_pkg;

	localparam int DATA_W = 32;

	// start and read command codes
	localparam logic [7:0] CMD_START_FL   = 8'h50;
	localparam logic [7:0] CMD_START_FH   = 8'h51;
	localparam logic [7:0] CMD_START_FAST1 = 8'h52;
	localparam logic [7:0] CMD_START_FAST2 = 8'h53;
	localparam logic [7:0] CMD_PRE_FIRST  = 8'hC0;
	localparam logic [7:0] CMD_PRE_LAST   = 8'hCC;
	localparam logic [7:0] CMD_WORK_FIRST = 8'hD0;
	localparam logic [7:0] CMD_WORK_LAST  = 8'hDB;
	localparam logic [7:0] CMD_ENV_FIRST  = 8'hDC;
	localparam logic [7:0] CMD_ENV_LAST   = 8'hE2;
	localparam logic [7:0] CMD_CNT_FIRST  = 8'hE3;
	localparam logic [7:0] CMD_CNT_LAST   = 8'hE6;
	localparam logic [7:0] CMD_CMP_FIRST  = 8'hE7;
	localparam logic [7:0] CMD_CMP_LAST   = 8'hEB;
	localparam logic [7:0] CMD_IRQ_EN     = 8'hEC;
	localparam logic [7:0] CMD_LTC_FIRST  = 8'hED;
	localparam logic [7:0] CMD_LTC_LAST   = 8'hF0;
	localparam logic [7:0] CMD_EXT_STS    = 8'hF1;
	localparam logic [7:0] CMD_ERR_STS    = 8'hF2;
	localparam logic [7:0] CMD_EVT_STS    = 8'hF3;
	localparam logic [7:0] CMD_REM_PLS    = 8'hF4;
	localparam logic [7:0] CMD_CUR_SPD    = 8'hF5;
	localparam logic [7:0] CMD_RAMP_PT    = 8'hF6;
	localparam logic [7:0] CMD_CIRC_DATA  = 8'hFC;
	localparam logic [7:0] CMD_CIRC_CNT   = 8'hFD;

	// main status word bit positions
	localparam int MS_START_WR  = 0;
	localparam int MS_STARTING  = 1;
	localparam int MS_STOP_IRQ  = 2;
	localparam int MS_STOPPED   = 3;
	localparam int MS_ERR_IRQ   = 4;
	localparam int MS_EVT_IRQ   = 5;
	localparam int MS_SEQ_LO    = 6;
	localparam int MS_CMP_LO    = 8;
	localparam int MS_OVR_FAIL  = 13;
	localparam int MS_NEXT_FULL = 14;
	localparam int MS_CMP5_FULL = 15;

	// sub status word bit positions
	localparam int SS_ACCEL    = 8;
	localparam int SS_DECEL    = 9;
	localparam int SS_CONST    = 10;
	localparam int SS_ALARM    = 11;
	localparam int SS_PLUS_EL  = 12;
	localparam int SS_MINUS_EL = 13;
	localparam int SS_ORIGIN   = 14;
	localparam int SS_RAMP_LT  = 15;

	// environment setting one bit positions
	localparam int ENV_RAMP_ACT  = 4;
	localparam int ENV_RAMP_LTCH = 5;
	localparam int ENV_RAMP_POL  = 6;
	localparam int ENV_START_TRG = 18;
	localparam int ENV_STOP_METH = 19;

	localparam logic [DATA_W-1:0] BUF_RESET = 32'h0000_0000;
	localparam logic [15:0]       STS_RESET = 16'h0000;

	// register sources grouped for the read multiplexer
	typedef struct packed {
		logic [12:0][DATA_W-1:0] pre;
		logic [11:0][DATA_W-1:0] work;
		logic [6:0][DATA_W-1:0]  env;
		logic [3:0][DATA_W-1:0]  cnt;
		logic [4:0][DATA_W-1:0]  cmp;
		logic [3:0][DATA_W-1:0]  ltc;
		logic [DATA_W-1:0]       irq_en;
		logic [DATA_W-1:0]       extension_status;
		logic [DATA_W-1:0]       error_irq_status;
		logic [DATA_W-1:0]       event_irq_status;
		logic [DATA_W-1:0]       remaining_pulse_count;
		logic [DATA_W-1:0]       current_speed_monitor;
		logic [DATA_W-1:0]       auto_rampdown_point;
		logic [DATA_W-1:0]       circ_step_data;
		logic [DATA_W-1:0]       circ_step_counter;
	} reg_src_s;

	// motion state reported by the pulse datapath
	typedef struct packed {
		logic       stopped_event;
		logic       override_fail_event;
		logic       error_irq_flag;
		logic       event_irq_flag;
		logic [1:0] seq_code;
		logic [4:0] cmp_met;
		logic       next_op_queue_full;
		logic       cmp5_queue_full;
		logic       accelerating_flag;
		logic       decelerating_flag;
		logic       constant_feed_flag;
	} motion_sts_s;

	// start profile decoded from a start command
	typedef enum logic [2:0] {
		PROF_NONE,
		PROF_INIT_CONST,
		PROF_RUN_CONST,
		PROF_CONST_DECEL,
		PROF_ACC_CONST_DECEL
	} start_prof_e;

	typedef enum logic [1:0] {
		RUN_IDLE,
		RUN_STARTING,
		RUN_STOPPED
	} run_state_e;

	// true when code lies in the inclusive range
	function automatic logic in_range(input logic [7:0] code, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (code >= lo) && (code <= hi);
	endfunction

endpackage

// [src/motion_in_sync.sv]
// file: three-stage synchroniser with agreement filter for one pin
// assumes: input is asynchronous to clk_sys
`timescale 1ns/10ps
module motion_in_sync (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// pin and filtered level
	input  wire logic pin_in,
	output logic      level_out
);
	typedef struct packed {
		logic [2:0] sh;
		logic       lvl;
	} sync_state_s;

	sync_state_s st_q;
	sync_state_s st_d;

	// shift in, accept change once stages two and three agree
	always_comb begin
		st_d     = st_q;
		st_d.sh  = {st_q.sh[1:0], pin_in};
		if (st_q.sh[1] == st_q.sh[2]) begin
			st_d.lvl = st_q.sh[2];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level_out = st_q.lvl;
endmodule

// [src/motion_input_opts.sv]
// file: decodes stop, start and ramp-down input options
// assumes: inputs already synchronised to clk_sys, env bits from env setting one
`timescale 1ns/10ps
module motion_input_opts
	import motion_rd_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// configuration
	input  wire logic [31:0] env_setting_one,
	// synchronised inputs, stop and start high when asserted, ramp level as at the pin
	input  wire logic        stop_lvl,
	input  wire logic        start_lvl,
	input  wire logic        ramp_lvl,
	input  wire logic        ramp_clear,
	// decoded requests
	output logic             stop_now,
	output logic             stop_decel,
	output logic             start_req,
	output logic             ramp_active,
	output logic             ramp_latched,
	output logic             ramp_decel,
	output logic             ramp_stop
);
	typedef struct packed {
		logic start_prev;
		logic ramp_lt;
	} opt_state_s;

	opt_state_s st_q;
	opt_state_s st_d;
	logic       ramp_on;

	// ramp-down polarity: 0 negative, 1 positive
	assign ramp_on = env_setting_one[ENV_RAMP_POL] ? ramp_lvl : ~ramp_lvl;

	// latch enabled when bit is 0; a new assertion wins over a clear
	always_comb begin
		st_d            = st_q;
		st_d.start_prev = start_lvl;
		if (ramp_clear) begin
			st_d.ramp_lt = 1'b0;
		end
		if (ramp_on && !env_setting_one[ENV_RAMP_LTCH]) begin
			st_d.ramp_lt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// stop reaction: 0 immediate, 1 deceleration
	assign stop_now   = stop_lvl & ~env_setting_one[ENV_STOP_METH];
	assign stop_decel = stop_lvl & env_setting_one[ENV_STOP_METH];
	// start sampling: 0 level, 1 rising edge
	assign start_req  = env_setting_one[ENV_START_TRG] ? (start_lvl & ~st_q.start_prev)
		: start_lvl;
	assign ramp_active  = ramp_on | st_q.ramp_lt;
	assign ramp_latched = st_q.ramp_lt;
	// ramp action: 0 decelerate only, 1 decelerate then stop
	assign ramp_decel = ramp_active;
	assign ramp_stop  = ramp_active & env_setting_one[ENV_RAMP_ACT];

	a_stop_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
		stop_lvl |-> (stop_now != stop_decel))
		else $error("stop reaction not exclusive");
	a_edge_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(env_setting_one[ENV_START_TRG] && start_req) |-> ##1 !start_req)
		else $error("edge start held longer than one cycle");
endmodule

// [src/motion_reg_readout.sv]
// file: command-driven register read-out and status packing for one axis
// assumes: host writes an 8-bit code with cmd_valid for one cycle; register
//          contents and motion state come from the datapath on clk_sys
// What this block does
// - C0h-CCh copy pre-register into buffer
// - DCh-E2h copy environment registers one-seven
// - E3h-E6h copy the four counters
// - E7h-EBh copy comparator one-five data
// - EDh-F0h copy latched counters one-four
// - F1h-F6h copy status, pulses, speed, ramp point
// - D0h-DBh copy working registers into buffer
// - FCh/FDh copy circular step data, counter
// - main bits 0,1,3: start written, starting, stopped
// - main bit 2 set on stop interrupt
// - main bit 13 set on override failure
// - main bits 4,5 error and event interrupt
// - main bits 8-12 comparator conditions met
// - main bits 14,15 queue full flags
// - sub bits 8-10 accel, decel, constant feed
// - sub bits 11-15 alarm, limits, origin, ramp latch
// - env bit 19 stop input: immediate or decel
// - env bit 18 start input: level or edge, but the decoded request never starts a motion
// - env bits 6,5 ramp polarity and latch
// - env bit 4 ramp action: decel or stop
// - 50h-53h start profiles
// - main status read clears bits 2, 13
`timescale 1ns/10ps
module motion_reg_readout
	import motion_rd_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	// host command and buffer
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_code,
	input  wire logic              buf_wr,
	input  wire logic [DATA_W-1:0] buf_wdata,
	input  wire logic              main_status_rd,
	output logic [DATA_W-1:0]      io_buffer,
	output logic                   cmd_unmapped,
	// register sources and motion state
	input  wire reg_src_s          reg_src,
	input  wire motion_sts_s       mot_sts,
	input  wire logic              motion_done,
	// pins, asynchronous
	input  wire logic              alarm_pin,
	input  wire logic              plus_el_pin,
	input  wire logic              minus_el_pin,
	input  wire logic              origin_pin,
	input  wire logic              rampdown_pin,
	input  wire logic              ext_stop_input_n,
	input  wire logic              ext_start_input_n,
	// status words
	output logic [15:0]            main_status_word,
	output logic [15:0]            sub_status_word,
	// start and stop requests to the pulse datapath
	output logic                   start_pulse,
	output start_prof_e            start_profile,
	output logic                   stop_now,
	output logic                   stop_decel,
	output logic                   ramp_decel,
	output logic                   ramp_stop
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] buf_val;
		logic              unmapped;
		logic              start_wr;
		run_state_e        run;
		logic              stop_irq;
		logic              ovr_fail;
		logic              start_pls;
		start_prof_e       prof;
		logic [15:0]       main_sts;
		logic [15:0]       sub_sts;
	} rd_state_s;

	rd_state_s st_q;
	rd_state_s st_d;

	logic alarm_s;
	logic plus_el_s;
	logic minus_el_s;
	logic origin_s;
	logic ramp_s;
	logic stop_s;
	logic start_s;
	logic ext_start_req;
	logic ramp_latched;
	logic ramp_act;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	motion_in_sync u_sync_alarm (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(alarm_pin), .level_out(alarm_s));
	motion_in_sync u_sync_pel (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(plus_el_pin), .level_out(plus_el_s));
	motion_in_sync u_sync_mel (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(minus_el_pin), .level_out(minus_el_s));
	motion_in_sync u_sync_org (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(origin_pin), .level_out(origin_s));
	motion_in_sync u_sync_ramp (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(rampdown_pin), .level_out(ramp_s));
	motion_in_sync u_sync_stop (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(~ext_stop_input_n), .level_out(stop_s));
	motion_in_sync u_sync_start (.clk_sys(clk_sys), .arst_n(arst_n),
		.pin_in(~ext_start_input_n), .level_out(start_s));

	// ****************************************************************
	// input option decoding
	// ****************************************************************
	motion_input_opts u_opts (
		.clk_sys         (clk_sys),
		.arst_n          (arst_n),
		.env_setting_one (reg_src.env[0]),
		.stop_lvl        (stop_s),
		.start_lvl       (start_s),
		.ramp_lvl        (ramp_s),
		.ramp_clear      (st_q.start_pls),
		.stop_now        (stop_now),
		.stop_decel      (stop_decel),
		.start_req       (ext_start_req),
		.ramp_active     (ramp_act),
		.ramp_latched    (ramp_latched),
		.ramp_decel      (ramp_decel),
		.ramp_stop       (ramp_stop)
	);

	// ****************************************************************
	// read multiplexer, returns 1 in hit when the code is mapped
	// ****************************************************************
	function automatic logic [DATA_W:0] read_mux(input logic [7:0] c, input reg_src_s r);
		logic [DATA_W-1:0] v;
		logic              hit;
		v   = BUF_RESET;
		hit = 1'b1;
		if (in_range(c, CMD_PRE_FIRST, CMD_PRE_LAST)) begin
			v = r.pre[4'(c - CMD_PRE_FIRST)];
		end else if (in_range(c, CMD_WORK_FIRST, CMD_WORK_LAST)) begin
			v = r.work[4'(c - CMD_WORK_FIRST)];
		end else if (in_range(c, CMD_ENV_FIRST, CMD_ENV_LAST)) begin
			v = r.env[3'(c - CMD_ENV_FIRST)];
		end else if (in_range(c, CMD_CNT_FIRST, CMD_CNT_LAST)) begin
			v = r.cnt[2'(c - CMD_CNT_FIRST)];
		end else if (in_range(c, CMD_CMP_FIRST, CMD_CMP_LAST)) begin
			v = r.cmp[3'(c - CMD_CMP_FIRST)];
		end else if (c == CMD_IRQ_EN) begin
			v = r.irq_en;
		end else if (in_range(c, CMD_LTC_FIRST, CMD_LTC_LAST)) begin
			v = r.ltc[2'(c - CMD_LTC_FIRST)];
		end else if (c == CMD_EXT_STS) begin
			v = r.extension_status;
		end else if (c == CMD_ERR_STS) begin
			v = r.error_irq_status;
		end else if (c == CMD_EVT_STS) begin
			v = r.event_irq_status;
		end else if (c == CMD_REM_PLS) begin
			v = r.remaining_pulse_count;
		end else if (c == CMD_CUR_SPD) begin
			v = r.current_speed_monitor;
		end else if (c == CMD_RAMP_PT) begin
			v = r.auto_rampdown_point;
		end else if (c == CMD_CIRC_DATA) begin
			v = r.circ_step_data;
		end else if (c == CMD_CIRC_CNT) begin
			v = r.circ_step_counter;
		end else begin
			hit = 1'b0;
		end
		read_mux = {hit, v};
	endfunction

	// start profile decode
	function automatic start_prof_e start_decode(input logic [7:0] c);
		case (c)
			CMD_START_FL:    start_decode = PROF_INIT_CONST;
			CMD_START_FH:    start_decode = PROF_RUN_CONST;
			CMD_START_FAST1: start_decode = PROF_CONST_DECEL;
			CMD_START_FAST2: start_decode = PROF_ACC_CONST_DECEL;
			default:         start_decode = PROF_NONE;
		endcase
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	logic [DATA_W:0] mux_res;
	start_prof_e     dec_prof;

	always_comb begin
		mux_res      = read_mux(cmd_code, reg_src);
		dec_prof     = start_decode(cmd_code);
		st_d         = st_q;
		st_d.start_pls = 1'b0;

		// buffer only changes on a host write or a mapped read command
		if (buf_wr) begin
			st_d.buf_val = buf_wdata;
		end
		if (cmd_valid) begin
			st_d.unmapped = 1'b0;
			if (mux_res[DATA_W]) begin
				st_d.buf_val = mux_res[DATA_W-1:0];
			end else if (dec_prof == PROF_NONE) begin
				st_d.unmapped = 1'b1;
			end
		end

		// start from a command only; the external start branch needs start_wr set outside RUN_STARTING, which never holds
		if (cmd_valid && dec_prof != PROF_NONE) begin
			st_d.start_wr  = 1'b1;
			st_d.start_pls = 1'b1;
			st_d.prof      = dec_prof;
			st_d.run       = RUN_STARTING;
		end else if (ext_start_req && st_q.start_wr && st_q.run != RUN_STARTING) begin
			st_d.start_pls = 1'b1;
			st_d.run       = RUN_STARTING;
		end

		// run sequencing
		case (st_q.run)
			RUN_IDLE: begin
			end
			RUN_STARTING: begin
				if (motion_done || stop_now) begin
					st_d.run      = RUN_STOPPED;
					st_d.start_wr = 1'b0;
				end
			end
			RUN_STOPPED: begin
			end
			default: st_d.run = RUN_IDLE;
		endcase

		// read clears the sticky flags, a new event wins
		if (main_status_rd) begin
			st_d.stop_irq = 1'b0;
			st_d.ovr_fail = 1'b0;
		end
		if (mot_sts.stopped_event) begin
			st_d.stop_irq = 1'b1;
		end
		if (mot_sts.override_fail_event) begin
			st_d.ovr_fail = 1'b1;
		end

		// main status packing
		st_d.main_sts = STS_RESET;
		st_d.main_sts[MS_START_WR]  = st_d.start_wr;
		st_d.main_sts[MS_STARTING]  = (st_d.run == RUN_STARTING);
		st_d.main_sts[MS_STOP_IRQ]  = st_d.stop_irq;
		st_d.main_sts[MS_STOPPED]   = (st_d.run == RUN_STOPPED);
		st_d.main_sts[MS_ERR_IRQ]   = mot_sts.error_irq_flag;
		st_d.main_sts[MS_EVT_IRQ]   = mot_sts.event_irq_flag;
		st_d.main_sts[MS_SEQ_LO +: 2] = mot_sts.seq_code;
		st_d.main_sts[MS_CMP_LO +: 5] = mot_sts.cmp_met;
		st_d.main_sts[MS_OVR_FAIL]  = st_d.ovr_fail;
		st_d.main_sts[MS_NEXT_FULL] = mot_sts.next_op_queue_full;
		st_d.main_sts[MS_CMP5_FULL] = mot_sts.cmp5_queue_full;

		// sub status packing
		st_d.sub_sts = STS_RESET;
		st_d.sub_sts[SS_ACCEL]    = mot_sts.accelerating_flag;
		st_d.sub_sts[SS_DECEL]    = mot_sts.decelerating_flag;
		st_d.sub_sts[SS_CONST]    = mot_sts.constant_feed_flag;
		st_d.sub_sts[SS_ALARM]    = alarm_s;
		st_d.sub_sts[SS_PLUS_EL]  = plus_el_s;
		st_d.sub_sts[SS_MINUS_EL] = minus_el_s;
		st_d.sub_sts[SS_ORIGIN]   = origin_s;
		st_d.sub_sts[SS_RAMP_LT]  = ramp_latched;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q          <= '0;
			st_q.buf_val  <= BUF_RESET;
			st_q.run      <= RUN_IDLE;
			st_q.prof     <= PROF_NONE;
			st_q.main_sts <= STS_RESET;
			st_q.sub_sts  <= STS_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign io_buffer        = st_q.buf_val;
	assign cmd_unmapped     = st_q.unmapped;
	assign main_status_word = st_q.main_sts;
	assign sub_status_word  = st_q.sub_sts;
	assign start_pulse      = st_q.start_pls;
	assign start_profile    = st_q.prof;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_read_cmd(logic [7:0] lo, logic [7:0] hi);
		cmd_valid && !buf_wr && cmd_code >= lo && cmd_code <= hi;
	endsequence

	a_pre_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_PRE_FIRST, CMD_PRE_LAST) |=>
		io_buffer == $past(reg_src.pre[4'(cmd_code - CMD_PRE_FIRST)]))
		else $error("pre-register copy wrong");
	a_env_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_ENV_FIRST, CMD_ENV_LAST) |=>
		io_buffer == $past(reg_src.env[3'(cmd_code - CMD_ENV_FIRST)]))
		else $error("environment copy wrong");
	a_cnt_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_CNT_FIRST, CMD_CNT_LAST) |=>
		io_buffer == $past(reg_src.cnt[2'(cmd_code - CMD_CNT_FIRST)]))
		else $error("counter copy wrong");
	a_cmp_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_CMP_FIRST, CMD_CMP_LAST) |=>
		io_buffer == $past(reg_src.cmp[3'(cmd_code - CMD_CMP_FIRST)]))
		else $error("comparator copy wrong");
	a_ltc_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_LTC_FIRST, CMD_LTC_LAST) |=>
		io_buffer == $past(reg_src.ltc[2'(cmd_code - CMD_LTC_FIRST)]))
		else $error("latch copy wrong");
	a_speed_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_CUR_SPD, CMD_CUR_SPD) |=>
		io_buffer == $past(reg_src.current_speed_monitor))
		else $error("speed copy wrong");
	a_work_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_WORK_FIRST, CMD_WORK_LAST) |=>
		io_buffer == $past(reg_src.work[4'(cmd_code - CMD_WORK_FIRST)]))
		else $error("working register copy wrong");
	a_circ_copy: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_CIRC_CNT, CMD_CIRC_CNT) |=>
		io_buffer == $past(reg_src.circ_step_counter))
		else $error("circular counter copy wrong");
	a_start_flags: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_read_cmd(CMD_START_FL, CMD_START_FAST2) ##1 !motion_done && !stop_now |=>
		main_status_word[MS_START_WR] && main_status_word[MS_STARTING])
		else $error("start flags not set");
	a_stop_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
		mot_sts.stopped_event |=> main_status_word[MS_STOP_IRQ])
		else $error("stop interrupt flag missing");
	a_read_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		main_status_rd && !mot_sts.override_fail_event |=> !main_status_word[MS_OVR_FAIL])
		else $error("override flag not cleared by read");
	a_buf_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!cmd_valid && !buf_wr |=> $stable(io_buffer))
		else $error("buffer changed without command");
endmodule

// [tb/motion_src_model.sv]
// file: datapath register source model, one pattern word per read code
// assumes: words are static, so the bench can predict every read
`timescale 1ns/10ps
module motion_src_model
	import motion_rd_pkg::*;
(
	// register contents
	output reg_src_s reg_src
);
	// pattern word tied to the code that reads it
	function automatic logic [31:0] pat(input logic [7:0] c);
		return {c, ~c, c, 8'h3C};
	endfunction
	// each field carries its own read code
	always_comb begin
		for (int k = 0; k < 13; k++) reg_src.pre[k] = pat(8'hC0 + 8'(k));
		for (int k = 0; k < 12; k++) reg_src.work[k] = pat(8'hD0 + 8'(k));
		for (int k = 0; k < 7; k++) reg_src.env[k] = pat(8'hDC + 8'(k));
		for (int k = 0; k < 4; k++) reg_src.cnt[k] = pat(8'hE3 + 8'(k));
		for (int k = 0; k < 5; k++) reg_src.cmp[k] = pat(8'hE7 + 8'(k));
		for (int k = 0; k < 4; k++) reg_src.ltc[k] = pat(8'hED + 8'(k));
		reg_src.irq_en = pat(8'hEC);
		reg_src.extension_status = pat(8'hF1);
		reg_src.error_irq_status = pat(8'hF2);
		reg_src.event_irq_status = pat(8'hF3);
		reg_src.remaining_pulse_count = pat(8'hF4);
		reg_src.current_speed_monitor = pat(8'hF5);
		reg_src.auto_rampdown_point = pat(8'hF6);
		reg_src.circ_step_data = pat(8'hFC);
		reg_src.circ_step_counter = pat(8'hFD);
	end
endmodule

// [tb/motion_register_read_and_status_tb.sv]
// file: self-checking bench for the read-out block
// assumes: source model words follow pat(); pins settle within 6 edges
`timescale 1ns/10ps
module motion_register_read_and_status_tb;
	import motion_rd_pkg::*;
	logic clk_sys, arst_n, cmd_valid, buf_wr, main_status_rd, start_pulse;
	logic [7:0] cmd_code, c;
	logic [31:0] buf_wdata, io_buffer, held;
	logic [15:0] main_status_word, sub_status_word;
	logic [3:0] pins;
	logic done, stop_n, ramp_pin, unmapped, stop_now, stop_decel, ramp_decel, ramp_stop;
	motion_sts_s mot_sts;
	reg_src_s reg_src;
	start_prof_e start_profile;
	int n_fail, samples_checked, seed;
	motion_src_model SRC (.reg_src(reg_src));
	motion_reg_readout DUT (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
		.main_status_rd(main_status_rd), .io_buffer(io_buffer), .cmd_unmapped(unmapped),
		.reg_src(reg_src), .mot_sts(mot_sts), .motion_done(done), .alarm_pin(pins[0]),
		.plus_el_pin(pins[1]), .minus_el_pin(pins[2]), .origin_pin(pins[3]),
		.rampdown_pin(ramp_pin), .ext_stop_input_n(stop_n), .ext_start_input_n(1'b1),
		.main_status_word(main_status_word), .sub_status_word(sub_status_word),
		.start_pulse(start_pulse), .start_profile(start_profile), .stop_now(stop_now),
		.stop_decel(stop_decel), .ramp_decel(ramp_decel), .ramp_stop(ramp_stop));
	function automatic logic [31:0] pat(input logic [7:0] c);
		return {c, ~c, c, 8'h3C};
	endfunction
	function automatic bit mapped(input logic [7:0] c);
		return (c >= 8'hC0 && c <= 8'hCC) || (c >= 8'hD0 && c <= 8'hF6) || c == 8'hFC || c == 8'hFD;
	endfunction
	task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_s(input string n, input logic [15:0] e, input logic [15:0] g);
		chk_w(n, {16'h0000, e}, {16'h0000, g});
	endtask
	// one command strobe, result settled after the taking edge
	task automatic cmd(input logic [7:0] k);
		@(posedge clk_sys) cmd_valid <= 1'b1;
		cmd_code <= k;
		@(posedge clk_sys) cmd_valid <= 1'b0;
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
	initial begin
		seed = 7; n_fail = 0; samples_checked = 0; arst_n = 1'b0; cmd_valid = 1'b0;
		cmd_code = 8'h00; buf_wr = 1'b0; buf_wdata = '0; main_status_rd = 1'b0;
		mot_sts = '0; pins = 4'h0;
		done = 1'b0; stop_n = 1'b1; ramp_pin = 1'b1;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		// every read code in order
		for (int k = 8'hC0; k <= 8'hFF; k++) if (mapped(8'(k))) begin
			cmd(8'(k));
			chk_w("read", pat(8'(k)), io_buffer);
		end
		// random codes with one idle cycle between, unmapped ones keep the buffer
		repeat (200) begin
			c = 8'hC0 | 8'($random(seed) & 8'h3F);
			held = io_buffer;
			cmd(c);
			chk_w("rand", mapped(c) ? pat(c) : held, io_buffer);
			chk_w("unmap", {31'h0, !mapped(c)}, {31'h0, unmapped});
		end
		// host write survives an unmapped code
		@(posedge clk_sys) buf_wr <= 1'b1;
		buf_wdata <= $random(seed);
		@(posedge clk_sys) buf_wr <= 1'b0;
		cmd(8'hF9);
		chk_w("hold", buf_wdata, io_buffer);
		// datapath levels and pins reach the status words
		repeat (20) begin
			@(posedge clk_sys) mot_sts <= 16'($random(seed));
			pins <= 4'($random(seed));
			repeat (6) @(posedge clk_sys);
			#1 chk_s("main", {mot_sts.cmp5_queue_full, mot_sts.next_op_queue_full, 1'b0,
				mot_sts.cmp_met, mot_sts.seq_code, mot_sts.event_irq_flag, mot_sts.error_irq_flag,
				4'h0}, main_status_word & 16'hDFF0);
			chk_s("sub", {1'b0, pins, mot_sts.constant_feed_flag, mot_sts.decelerating_flag,
				mot_sts.accelerating_flag, 8'h00}, sub_status_word & 16'h7F00);
		end
		// sticky stop and override flags, cleared by a status read
		@(posedge clk_sys) mot_sts <= 16'hC000; // stopped and override-fail events
		@(posedge clk_sys) mot_sts <= '0;
		repeat (3) @(posedge clk_sys);
		#1 chk_s("sticky", 16'h2004, main_status_word & 16'h2004);
		@(posedge clk_sys) main_status_rd <= 1'b1;
		@(posedge clk_sys) main_status_rd <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk_s("clear", 16'h0000, main_status_word & 16'h2004);
		// every start code and its profile
		for (int k = 0; k < 4; k++) begin
			cmd(8'h50 + 8'(k));
			chk_w("pulse", 32'h0000_0001, {31'h0, start_pulse});
			chk_w("prof", 32'(k + 1), 32'(start_profile));
			repeat (2) @(posedge clk_sys);
			#1 chk_s("run", 16'h0003, main_status_word & 16'h0003);
		end
		// motion end, then a restart ended by the stop pin; ramp pin active low
		@(posedge clk_sys) done <= 1'b1;
		@(posedge clk_sys) done <= 1'b0;
		#1 chk_s("done", 16'h0008, main_status_word & 16'h000B);
		cmd(8'h52);
		@(posedge clk_sys) stop_n <= 1'b0;
		ramp_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1 chk_w("stop", 32'h2, {30'h0, stop_now, stop_decel});
		chk_w("ramp", 32'h3, {30'h0, ramp_decel, ramp_stop});
		chk_s("halt", 16'h0008, main_status_word & 16'h000B);
		conclude();
	end
endmodule
